// ===== eipu_defines.svh
// Purpose: Constants of the external pin interrupt unit
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are byte addresses on the plain register port
`ifndef EIPU_DEFINES_SVH
`define EIPU_DEFINES_SVH

// Register offsets
`define EIPU_OFF_CTL      8'h00
`define EIPU_OFF_CTLSTAT  8'h01
`define EIPU_OFF_ENABLE   8'h02
`define EIPU_OFF_FLAGS    8'h03

// Field positions
`define EIPU_SENSE0_LO    0
`define EIPU_SENSE0_HI    1
`define EIPU_SENSE1_LO    2
`define EIPU_SENSE1_HI    3
`define EIPU_EDGE2_POS    6
`define EIPU_LINE1_POS    7
`define EIPU_LINE0_POS    6
`define EIPU_LINE2_POS    5

// Reset values
`define EIPU_CTL_RST      8'h00
`define EIPU_EDGE2_RST    1'b0
`define EIPU_ENABLE_RST   3'h0
`define EIPU_FLAGS_RST    3'h0
`define EIPU_PIN_RST      1'b1

// Timing
`define EIPU_CLK_NS       40
`define EIPU_T_INT_NS     50
`define EIPU_MIN_PULSE_CYC \
  ((`EIPU_T_INT_NS + `EIPU_CLK_NS - 1) / `EIPU_CLK_NS)
`define EIPU_WAKE_SAMPLES 2'h2

`endif

// ===== eipu_pkg.sv
// Purpose: Types of the external pin interrupt unit
// Assumes: Compiled before the modules
// Notes:   Sense order matches the two-bit control field
package eipu_pkg;

  typedef enum logic [1:0] {
    SENSE_LOW,
    SENSE_ANY,
    SENSE_FALL,
    SENSE_RISE
  } eipu_sense_t;

  typedef enum logic [1:0] {
    WK_RUN,
    WK_SLEEP,
    WK_WAKE
  } eipu_wake_t;

endpackage

// ===== eipu_pin_sync.sv
// Purpose: Three-stage input sampler with agreement filter
// Assumes: rawIn is asynchronous to clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
`include "eipu_defines.svh"
module eipu_pin_sync (
  input  wire logic clk,    // Unit clock
  input  wire logic reset,  // Async reset, active high
  input  wire logic rawIn,  // Pad level
  output logic      level   // Filtered level
);
  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1_q <= `EIPU_PIN_RST;
      stage2_q <= `EIPU_PIN_RST;
      stage3_q <= `EIPU_PIN_RST;
      level_q  <= `EIPU_PIN_RST;
    end else begin
      stage1_q <= rawIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        level_q <= stage3_q;
      end
    end
  end

  assign level = level_q;
endmodule // eipu_pin_sync

// ===== eipu_top.sv
// Purpose: External pin interrupt unit, three request lines
// Assumes: clk keeps running; ioClkRun tells when the I/O clock runs
// Notes:   Each line has its own request output toward the CPU
//
// Behaviour
// RULE_01: Lines detect pin activity even while the pin is driven as output.
// RULE_02: Line two is edge only; low level only on lines zero and one.
// RULE_03: Low-level mode requests continuously while the pin stays low.
// RULE_04: Edges on lines zero/one need I/O clock; others work without.
// RULE_05: Power-down level wake needs two watchdog samples of the level.
// RULE_06: Level gone before start-up ends: wake, but no level request.
// RULE_07: Line one sense field bits 3:2: low, change, fall, rise.
// RULE_08: Line zero sense field bits 1:0 with the same encoding.
// RULE_09: Lines zero/one sample the pin before edge detection.
// RULE_10: Driver holds low level until the current instruction completes.
// RULE_11: Line two edge select bit 6: zero falling, one rising.
// RULE_12: Line two edges captured without the I/O clock.
// RULE_13: Software disables line two before changing its edge select.
// RULE_14: Service needs line enable (bits 7,6,5) and global enable.
// RULE_15: Each line has its own request and vector.
// RULE_16: Edge sets flag bit 7/6/5 for lines one/zero/two; rest read 0.
// RULE_17: Flag clears on routine entry or on a written one.
// RULE_18: Low-level mode holds the line's flag cleared.
// RULE_19: Buffer off with line two disabled may set its flag.
// RULE_20: Request is pin low or flag, and line and global enable.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "eipu_defines.svh"
module eipu_top (
  input  wire logic       clk,          // Unit clock, 25 MHz
  input  wire logic       reset,        // Async reset, active high
  input  wire logic [7:0] addr,         // Register address
  input  wire logic [7:0] wrData,       // Write data
  input  wire logic       wrStrobe,     // Write strobe
  input  wire logic       rdStrobe,     // Read strobe
  output logic      [7:0] rdData,       // Read data, cycle after strobe
  input  wire logic [2:0] pinIn,        // Pad levels of lines 2..0
  input  wire logic       cpuIntEnable, // Global enable of status word
  input  wire logic [2:0] irqAck,       // Routine entered, per line
  input  wire logic       ioClkRun,     // I/O clock running
  input  wire logic       powerDown,    // Power-down sleep active
  input  wire logic       bufferOff,    // Sleep input buffer disable
  input  wire logic       wdtClkIn,     // Watchdog oscillator clock
  output logic      [2:0] irqReq,       // Request per line to the CPU
  output logic            wakeReq       // Wake request from sleep
);
  import eipu_pkg::*;

  logic [7:0]  ctl_q;
  logic        edge2_q;
  logic [2:0]  enable_q;
  logic [2:0]  flags_q;
  logic [2:0]  flags_d;
  logic [2:0]  prev_q;
  logic [2:0]  irqReq_q;
  logic [2:0]  irqReq_d;
  logic [7:0]  rdData_q;
  logic [7:0]  rdData_d;
  logic        wakeReq_q;
  logic        wdtPrev_q;
  logic [1:0]  sampleCnt_q;
  eipu_wake_t  wake_q;
  eipu_wake_t  wake_d;

  logic [2:0]  pinLevel;
  logic [2:0]  lvl;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic [2:0]  chg;
  logic [2:0]  hit;
  logic [2:0]  levelMode;
  logic [2:0]  wrClr;
  logic [2:0]  clear;
  logic        wdtLevel;
  logic        wdtTick;
  logic        lowWake;
  logic        edgeWake;
  logic        wrCtl;
  logic        wrCtlStat;
  logic        wrEnable;
  logic        wrFlags;
  eipu_sense_t sense0;
  eipu_sense_t sense1;

  // RULE_09: pins sampled first
  // RULE_01: pad level seen whatever the pin direction
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      eipu_pin_sync u_sync (
        .clk   (clk),
        .reset (reset),
        .rawIn (pinIn[gi]),
        .level (pinLevel[gi])
      );
    end
  endgenerate

  eipu_pin_sync u_wdtSync (
    .clk   (clk),
    .reset (reset),
    .rawIn (wdtClkIn),
    .level (wdtLevel)
  );

  // Register decode
  assign wrCtl     = wrStrobe && (addr == `EIPU_OFF_CTL);
  assign wrCtlStat = wrStrobe && (addr == `EIPU_OFF_CTLSTAT);
  assign wrEnable  = wrStrobe && (addr == `EIPU_OFF_ENABLE);
  assign wrFlags   = wrStrobe && (addr == `EIPU_OFF_FLAGS);

  // RULE_07: line one sense field
  assign sense1 = eipu_sense_t'(ctl_q[`EIPU_SENSE1_HI:`EIPU_SENSE1_LO]);
  // RULE_08: line zero sense field
  assign sense0 = eipu_sense_t'(ctl_q[`EIPU_SENSE0_HI:`EIPU_SENSE0_LO]);

  // RULE_02: line two never in level mode
  assign levelMode = {1'b0, sense1 == SENSE_LOW, sense0 == SENSE_LOW};

  // RULE_19: disabled buffer reads low, may look like an edge
  assign lvl[1:0] = pinLevel[1:0];
  assign lvl[2]   = (bufferOff && !enable_q[2]) ? 1'b0 : pinLevel[2];

  assign rise = ~prev_q & lvl;
  assign fall = prev_q & ~lvl;
  assign chg  = prev_q ^ lvl;

  // RULE_04: edge sensing on lines zero and one needs the I/O clock
  generate
    for (gi = 0; gi < 2; gi++) begin : g_hit
      eipu_sense_t sense;
      assign sense = (gi == 0) ? sense0 : sense1;
      assign hit[gi] = ioClkRun &&
                       ((sense == SENSE_ANY  && chg[gi]) ||
                        (sense == SENSE_FALL && fall[gi]) ||
                        (sense == SENSE_RISE && rise[gi]));
    end
  endgenerate

  // RULE_11: line two edge polarity
  // RULE_12: line two edge independent of the I/O clock
  assign hit[2] = edge2_q ? rise[2] : fall[2];

  // RULE_17: write one clears, routine entry clears
  assign wrClr = {wrData[`EIPU_LINE2_POS], wrData[`EIPU_LINE1_POS],
                  wrData[`EIPU_LINE0_POS]};
  assign clear = irqAck | ({3{wrFlags}} & wrClr);

  // RULE_16: an edge sets the flag, set beats clear
  // RULE_18: level mode forces the flag clear
  assign flags_d = ~levelMode & (hit | (flags_q & ~clear));

  // RULE_20: level or flag request, gated by both enables
  // RULE_14: line enable and global enable
  // RULE_03: held while the pin stays low
  // RULE_06: a vanished level raises no request
  assign irqReq_d = {3{cpuIntEnable}} & enable_q &
                    ((levelMode & ~lvl) | (~levelMode & flags_q));

  // RULE_05: two watchdog samples of the wake level
  assign wdtTick  = wdtLevel && !wdtPrev_q;
  assign lowWake  = |(levelMode[1:0] & enable_q[1:0] & ~lvl[1:0]);
  assign edgeWake = enable_q[2] && hit[2];

  always_comb begin
    wake_d = wake_q;
    case (wake_q)
      WK_RUN: begin
        if (powerDown) begin
          wake_d = WK_SLEEP;
        end
      end
      WK_SLEEP: begin
        if (!powerDown) begin
          wake_d = WK_RUN;
        end else if (edgeWake || (wdtTick && lowWake &&
                     sampleCnt_q == `EIPU_WAKE_SAMPLES - 2'h1)) begin
          wake_d = WK_WAKE;
        end
      end
      WK_WAKE: begin
        if (!powerDown) begin
          wake_d = WK_RUN;
        end
      end
      default: wake_d = WK_RUN;
    endcase
  end

  // Read view, unused bits read zero
  always_comb begin
    rdData_d = 8'h00;
    if (rdStrobe) begin
      case (addr)
        `EIPU_OFF_CTL:     rdData_d = ctl_q;
        `EIPU_OFF_CTLSTAT: rdData_d[`EIPU_EDGE2_POS] = edge2_q;
        `EIPU_OFF_ENABLE: begin
          rdData_d[`EIPU_LINE0_POS] = enable_q[0];
          rdData_d[`EIPU_LINE1_POS] = enable_q[1];
          rdData_d[`EIPU_LINE2_POS] = enable_q[2];
        end
        `EIPU_OFF_FLAGS: begin
          rdData_d[`EIPU_LINE0_POS] = flags_q[0];
          rdData_d[`EIPU_LINE1_POS] = flags_q[1];
          rdData_d[`EIPU_LINE2_POS] = flags_q[2];
        end
        default: rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl_q    <= `EIPU_CTL_RST;
      edge2_q  <= `EIPU_EDGE2_RST;
      enable_q <= `EIPU_ENABLE_RST;
    end else begin
      if (wrCtl) begin
        ctl_q <= wrData;
      end
      // RULE_13: software sequences the select change itself
      if (wrCtlStat) begin
        edge2_q <= wrData[`EIPU_EDGE2_POS];
      end
      if (wrEnable) begin
        enable_q <= wrClr;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_q  <= `EIPU_FLAGS_RST;
      prev_q   <= {3{`EIPU_PIN_RST}};
      irqReq_q <= 3'h0;
      rdData_q <= 8'h00;
    end else begin
      flags_q  <= flags_d;
      prev_q   <= lvl;
      irqReq_q <= irqReq_d;
      rdData_q <= rdData_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_q      <= WK_RUN;
      wakeReq_q   <= 1'b0;
      wdtPrev_q   <= `EIPU_PIN_RST;
      sampleCnt_q <= 2'h0;
    end else begin
      wake_q    <= wake_d;
      wakeReq_q <= (wake_d == WK_WAKE);
      wdtPrev_q <= wdtLevel;
      if (wake_q != WK_SLEEP || (wdtTick && !lowWake)) begin
        sampleCnt_q <= 2'h0;
      end else if (wdtTick && sampleCnt_q != `EIPU_WAKE_SAMPLES) begin
        sampleCnt_q <= sampleCnt_q + 2'h1;
      end
    end
  end

  // RULE_15: one request output per line
  assign irqReq  = irqReq_q;
  assign wakeReq = wakeReq_q;
  assign rdData  = rdData_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_LEVEL_REQ: assert property ( // RULE_03
    levelMode[0] && enable_q[0] && cpuIntEnable && !lvl[0]
    |=> irqReq[0])
    else $error("level request missing while pin low");

  AST_LEVEL_NOFLAG: assert property ( // RULE_18
    levelMode[1] |=> !flags_q[1])
    else $error("flag set in level mode");

  AST_NO_IOCLK: assert property ( // RULE_04
    !ioClkRun && !flags_q[0] |=> !flags_q[0])
    else $error("line zero edge seen without I/O clock");

  AST_RISE_ZERO: assert property ( // RULE_08
    ioClkRun && sense0 == SENSE_RISE && rise[0] |=> flags_q[0])
    else $error("rising edge on line zero lost");

  AST_ANY_ONE: assert property ( // RULE_07
    ioClkRun && sense1 == SENSE_ANY && chg[1] |=> flags_q[1] ##1 irqReq[1]
    || !(enable_q[1] && cpuIntEnable))
    else $error("change on line one lost");

  AST_EDGE2_SEL: assert property ( // RULE_11
    edge2_q && fall[2] && !flags_q[2] |=> !flags_q[2])
    else $error("falling edge set flag in rising mode");

  AST_W1C: assert property ( // RULE_17
    wrFlags && wrData[`EIPU_LINE2_POS] && !hit[2] |=> !flags_q[2])
    else $error("write one did not clear line two flag");

  AST_ACK: assert property ( // RULE_17
    irqAck[0] && !hit[0] |=> !flags_q[0])
    else $error("routine entry did not clear line zero flag");

  AST_GLOBAL: assert property ( // RULE_14
    !cpuIntEnable |=> irqReq == 3'h0)
    else $error("request without global enable");

  AST_WAKE: assert property ( // RULE_05
    wake_q == WK_SLEEP && powerDown && wdtTick && lowWake &&
    sampleCnt_q == 2'h1 |=> wakeReq ##1 wakeReq || !powerDown)
    else $error("level wake missing after two samples");

  AST_FLAG_READ: assert property ( // RULE_16
    rdStrobe && addr == `EIPU_OFF_FLAGS
    |=> rdData[4:0] == 5'h00 && rdData[`EIPU_LINE2_POS] == $past(flags_q[2]))
    else $error("flag register read wrong");

  // Filtered level is what a two-cycle pulse is guaranteed to reach
  AST_MIN_PULSE: assert property ( // RULE_12
    !edge2_q && !bufferOff && $fell(pinLevel[2]) |-> ##1 flags_q[2])
    else $error("line two pulse not captured");

  AST_LEVEL_GONE: assert property ( // RULE_06
    levelMode[0] && lvl[0] |=> !irqReq[0])
    else $error("level request without low pin");

  AST_LINE_ENABLE: assert property ( // RULE_14
    !enable_q[2] |=> !irqReq[2])
    else $error("line two request while disabled");

  AST_CTLSTAT_READ: assert property ( // RULE_11
    rdStrobe && addr == `EIPU_OFF_CTLSTAT
    |=> rdData == {1'b0, $past(edge2_q), 6'h00})
    else $error("edge select read wrong");

  COV_LEVEL: cover property (levelMode[0] && irqReq[0]);
  COV_EDGE2: cover property (hit[2] ##1 flags_q[2] ##1 irqReq[2]);
  COV_WAKE:  cover property (wake_q == WK_SLEEP ##1 wake_q == WK_WAKE);
  COV_ANY:   cover property (sense1 == SENSE_ANY && hit[1]);
endmodule // eipu_top

// ===== eipu_pin_model.sv
// Purpose: Pads and CPU side facing the interrupt unit
// Assumes: One clock; a released pad is pulled up
// Notes:   CPU enters one routine at a time, lowest line first
`timescale 1ns/1ps
module eipu_pin_model (
  input  wire logic       clk,     // Unit clock
  input  wire logic       reset,   // Async reset, active high
  input  wire logic [2:0] irqReq,  // Requests from the unit
  input  wire logic [2:0] pinDrv,  // Level driven onto pads
  input  wire logic [2:0] pinEn,   // Pad driven, else pulled up
  input  wire logic       ackEn,   // CPU takes requests
  input  wire logic       ackSlow, // Long routine entry latency
  input  wire logic       wdtRun,  // Watchdog oscillator on
  output logic      [2:0] pinIn,   // Pad levels
  output logic      [2:0] irqAck,  // Routine entered, per line
  output logic            wdtClk   // Watchdog oscillator clock
);
  logic [3:0] ackCnt;
  logic [2:0] wdtCnt;
  logic [2:0] pick;

  // pad level held by the driver, or high through the pull-up when released
  assign pinIn = pinDrv | ~pinEn;
  assign pick = irqReq[0] ? 3'h1 : irqReq[1] ? 3'h2 : {irqReq[2], 2'h0};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ackCnt <= 4'h0;
      irqAck <= 3'h0;
    end else begin
      irqAck <= 3'h0;
      if (!ackEn || pick == 3'h0) begin
        ackCnt <= 4'h0;
      end else if (ackCnt == (ackSlow ? 4'ha : 4'h3)) begin
        ackCnt <= 4'h0;
        irqAck <= pick;
      end else begin
        ackCnt <= ackCnt + 4'h1;
      end
    end
  end

  // Oscillator stands still while off
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wdtCnt <= 3'h0;
      wdtClk <= 1'b0;
    end else if (!wdtRun) begin
      wdtCnt <= 3'h0;
      wdtClk <= 1'b0;
    end else begin
      wdtCnt <= (wdtCnt == 3'h5) ? 3'h0 : wdtCnt + 3'h1;
      wdtClk <= (wdtCnt == 3'h5) ? ~wdtClk : wdtClk;
    end
  end
endmodule // eipu_pin_model

// ===== test_external_pin_interrupt_unit.sv
// Purpose: Self-checking bench of the pin interrupt unit
// Assumes: Register port answers one cycle after a read strobe
// Notes:   Pulses last two cycles so the agree filter keeps them
`timescale 1ns/1ps
`include "eipu_defines.svh"
module test_external_pin_interrupt_unit;
  import eipu_pkg::*;
  logic       clk, reset, wrStrobe, rdStrobe, cpuIntEnable, ioClkRun;
  logic       powerDown, bufferOff, wdtClkIn, wakeReq;
  logic       ackEn, ackSlow, wdtRun;
  logic [7:0] addr, wrData, rdData;
  logic [2:0] pinIn, irqAck, irqReq, pinDrv, pinEn;
  int         n_fail, checked;
  wire  [3:0] outs = {wakeReq, irqReq};

  eipu_top dut (.clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .pinIn(pinIn), .cpuIntEnable(cpuIntEnable), .irqAck(irqAck),
    .ioClkRun(ioClkRun), .powerDown(powerDown), .bufferOff(bufferOff),
    .wdtClkIn(wdtClkIn), .irqReq(irqReq), .wakeReq(wakeReq));
  eipu_pin_model far (.clk(clk), .reset(reset), .irqReq(irqReq),
    .pinDrv(pinDrv), .pinEn(pinEn), .ackEn(ackEn), .ackSlow(ackSlow),
    .wdtRun(wdtRun), .pinIn(pinIn), .irqAck(irqAck), .wdtClk(wdtClkIn));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 chk(rdData, exp);
  endtask

  // Bounded wait on one request bit, or on wake as bit 3
  task automatic waitOut(input int n, input logic val);
    int i;
    for (i = 0; i < 120 && outs[n] !== val; i++) begin
      @(posedge clk);
      #1;
    end
    if (outs[n] !== val) begin
      chk({7'h0, outs[n]}, {7'h0, val});
      complete_run();
    end
  endtask

  function automatic logic [7:0] lineBit(input int n);
    return (n == 0) ? 8'h40 : (n == 1) ? 8'h80 : 8'h20;
  endfunction

  // Disabled while the pad settles, then flag cleared, then enabled
  task automatic arm(input int n, input logic [7:0] a, input logic [7:0] d,
                     input logic st);
    @(posedge clk);
    pinDrv[n] <= st;
    wr(`EIPU_OFF_ENABLE, 8'h00);
    cyc(6);
    wr(a, d);
    wr(`EIPU_OFF_FLAGS, 8'he0);
    wr(`EIPU_OFF_ENABLE, lineBit(n));
  endtask

  task automatic pulse(input int n, input logic st);
    @(posedge clk);
    pinDrv[n] <= ~st;
    cyc(2);
    pinDrv[n] <= st;
  endtask

  task automatic edgeTest(input int n, input logic [7:0] a,
                          input logic [7:0] d, input logic st,
                          input logic slow);
    arm(n, a, d, st);
    pulse(n, st);
    waitOut(n, 1'b1);
    chk({5'h0, irqReq}, 8'h1 << n);
    rdChk(`EIPU_OFF_FLAGS, lineBit(n));
    @(posedge clk);
    ackSlow <= slow;
    ackEn <= 1'b1;
    waitOut(n, 1'b0);
    @(posedge clk);
    ackEn <= 1'b0;
    rdChk(`EIPU_OFF_FLAGS, 8'h00);
  endtask

  initial begin
    {reset, cpuIntEnable, ioClkRun} = 3'b101;
    {addr, wrData, wrStrobe, rdStrobe} = 18'h0;
    {powerDown, bufferOff, ackEn, ackSlow, wdtRun} = 5'h0;
    {pinDrv, pinEn} = 6'h3f;
    {n_fail, checked} = 0;
    cyc(3);
    reset <= 1'b0;
    rdChk(`EIPU_OFF_CTL, 8'h00);
    rdChk(`EIPU_OFF_FLAGS, 8'h00);
    wr(`EIPU_OFF_CTL, 8'ha5);
    rdChk(`EIPU_OFF_CTL, 8'ha5);
    wr(`EIPU_OFF_CTLSTAT, 8'hff);
    rdChk(`EIPU_OFF_CTLSTAT, 8'h40);
    wr(`EIPU_OFF_ENABLE, 8'hff);
    rdChk(`EIPU_OFF_ENABLE, 8'he0);
    wr(8'h10, 8'hff);
    rdChk(8'h10, 8'h00);
    wr(`EIPU_OFF_FLAGS, 8'hff);
    rdChk(`EIPU_OFF_FLAGS, 8'h00);
    $display("test registers done");
    @(posedge clk);
    cpuIntEnable <= 1'b1;
    for (int n = 0; n < 2; n++) begin
      for (int m = 1; m < 4; m++) begin
        edgeTest(n, `EIPU_OFF_CTL, 8'(m << (2 * n)), m != 3, m == 2);
      end
    end
    $display("test sense modes done");
    @(posedge clk);
    cpuIntEnable <= 1'b0;
    arm(1, `EIPU_OFF_CTL, 8'h08, 1'b1);
    pulse(1, 1'b1);
    cyc(10);
    chk({5'h0, irqReq}, 8'h00);
    rdChk(`EIPU_OFF_FLAGS, 8'h80);
    @(posedge clk);
    cpuIntEnable <= 1'b1;
    waitOut(1, 1'b1);
    wr(`EIPU_OFF_FLAGS, 8'h80);
    waitOut(1, 1'b0);
    $display("test global enable done");
    arm(0, `EIPU_OFF_CTL, 8'h00, 1'b1);
    pinDrv[0] <= 1'b0;
    waitOut(0, 1'b1);
    repeat (12) begin
      @(posedge clk);
      #1 chk({7'h0, irqReq[0]}, 8'h01);
    end
    rdChk(`EIPU_OFF_FLAGS, 8'h00);
    @(posedge clk);
    // Released pad goes high through its pull-up
    pinEn[0] <= 1'b0;
    waitOut(0, 1'b0);
    $display("test low level done");
    @(posedge clk);
    {powerDown, ioClkRun, wdtRun, pinEn[0], pinDrv[0]} <= 5'b10111;
    cyc(4);
    pinDrv[0] <= 1'b0;
    waitOut(3, 1'b1);
    @(posedge clk);
    powerDown <= 1'b0;
    waitOut(3, 1'b0);
    @(posedge clk);
    {pinDrv[0], wdtRun} <= 2'b10;
    $display("test wake done");
    arm(0, `EIPU_OFF_CTL, 8'h02, 1'b1);
    pulse(0, 1'b1);
    cyc(10);
    chk({5'h0, irqReq}, 8'h00);
    rdChk(`EIPU_OFF_FLAGS, 8'h00);
    edgeTest(2, `EIPU_OFF_CTLSTAT, 8'h00, 1'b1, 1'b0);
    edgeTest(2, `EIPU_OFF_CTLSTAT, 8'h40, 1'b0, 1'b1);
    arm(2, `EIPU_OFF_CTLSTAT, 8'h00, 1'b1);
    wr(`EIPU_OFF_ENABLE, 8'h00);
    bufferOff <= 1'b1;
    cyc(10);
    rdChk(`EIPU_OFF_FLAGS, 8'h20);
    $display("test line two done");
    @(posedge clk);
    bufferOff <= 1'b0;
    wr(`EIPU_OFF_CTLSTAT, 8'h40);
    // Mid-run reset with a flag and the edge select set
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    rdChk(`EIPU_OFF_CTL, 8'h00);
    rdChk(`EIPU_OFF_CTLSTAT, 8'h00);
    rdChk(`EIPU_OFF_FLAGS, 8'h00);
    $display("test reset done");
    complete_run();
  end
endmodule // test_external_pin_interrupt_unit
